/* File: rtl/spread_spectrum_clock_select.sv */
`timescale 1ns/1ps
module spread_spectrum_clock_select
  import hop_clock_pkg::*;
#(
  parameter bit SPREAD_FITTED = 1'b1,
  parameter int LOCK_EDGES    = SYNC_LOCK_EDGES,
  parameter int WINDOW_CYCLES = SYNC_WINDOW_CYCLES
) (
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  // sync pin level (open reads low through the pulldown)
  input  wire logic       SYNC_IN,
  // load current condition per channel
  input  wire logic       LIGHT_LOAD_A,
  input  wire logic       LIGHT_LOAD_B,
  // oscillator control
  output logic [3:0]      HOP_VECTOR,
  output logic            FREQUENCY_HOP_SPREAD_ACTIVE,
  // channel clocks
  output logic            STEP_DOWN_CHANNEL_A_CLK,
  output logic            STEP_DOWN_CHANNEL_B_CLK,
  // mode status
  output logic            EXTERNAL_CLOCK_LOCKED,
  output logic            LIGHT_LOAD_SAVING_ALLOWED,
  output logic            PULSE_SKIP_OPERATION_A,
  output logic            PULSE_SKIP_OPERATION_B,
  output logic            SINK_ENABLE_A,
  output logic            SINK_ENABLE_B
);
  initial begin
    if (LOCK_EDGES < 2 || LOCK_EDGES > 15) $error("LOCK_EDGES must be 2..15");
    if (WINDOW_CYCLES < 2 || WINDOW_CYCLES > 4096) $error("WINDOW_CYCLES must be 2..4096");
  end

  function automatic logic [11:0] period_for(input logic [3:0] hop);
    // linear map of 16 steps onto +/- spread around nominal
    logic [15:0] span;
    span = 16'(hop) * 16'(2 * SPREAD_CYCLES) / 16'd15;
    return 12'(NOMINAL_CYCLES - SPREAD_CYCLES) + span[11:0];
  endfunction : period_for

  // sync edge qualification
  logic                sync_prev_reg;
  logic [11:0]         gap_reg;
  logic [11:0]         gap_next;
  logic [3:0]          edge_count_reg;
  logic [3:0]          edge_count_next;
  logic                locked_reg;
  logic                locked_next;
  logic [2:0]          level_count_reg;
  sync_mode_type       mode_reg;
  sync_mode_type       mode_next;
  wire                 rise;
  wire                 gap_expired;
  wire                 sync_steady;

  assign rise        = SYNC_IN && !sync_prev_reg;
  assign gap_expired = (gap_reg >= 12'(WINDOW_CYCLES - 1));
  assign gap_next    = rise ? 12'h000 : (gap_expired ? gap_reg : gap_reg + 12'h001);
  // only edges spaced within the window count toward lock
  assign edge_count_next = gap_expired ? (rise ? 4'h1 : 4'h0) :
                           (rise && edge_count_reg != 4'hF) ? edge_count_reg + 4'h1 :
                           edge_count_reg;
  assign locked_next = gap_expired ? 1'b0 :
                       (edge_count_reg >= 4'(LOCK_EDGES)) ? 1'b1 : locked_reg;
  // a few equal samples keep the level decision from chattering
  assign sync_steady = (level_count_reg == 3'(SYNC_LEVEL_CYCLES - 1));
  assign mode_next   = locked_next ? SYNC_EXTERNAL :
                       (!sync_steady && mode_reg != SYNC_EXTERNAL) ? mode_reg :
                       SYNC_IN ? SYNC_HIGH : SYNC_LOW;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sync_prev_reg   <= 1'b0;
      gap_reg         <= 12'h000;
      edge_count_reg  <= 4'h0;
      locked_reg      <= 1'b0;
      level_count_reg <= 3'h0;
      mode_reg        <= SYNC_LOW;
    end else begin
      sync_prev_reg   <= SYNC_IN;
      gap_reg         <= gap_next;
      edge_count_reg  <= edge_count_next;
      locked_reg      <= locked_next;
      level_count_reg <= (SYNC_IN != sync_prev_reg) ? 3'h0 :
                         (sync_steady ? level_count_reg : level_count_reg + 3'h1);
      mode_reg        <= mode_next;
    end
  end

  // mode decoding
  wire hop_enable;
  wire saving_allowed;
  assign hop_enable     = SPREAD_FITTED && (mode_reg == SYNC_HIGH);
  assign saving_allowed = (mode_reg == SYNC_LOW);

  // internal oscillator: one period per cycle, period chosen from hop vector
  logic [11:0] osc_count_reg;
  logic [11:0] period_reg;
  wire  [3:0]  hop_vector;
  wire         osc_wrap;
  wire         half_point;
  wire  [11:0] osc_count_next;

  assign osc_wrap       = (osc_count_reg >= period_reg - 12'h001);
  // one early so the registered b pulse lands half a period, rounded down for odd periods, after a
  assign half_point     = (osc_count_reg == (period_reg >> 1) - 12'h001);
  assign osc_count_next = osc_wrap ? 12'h000 : osc_count_reg + 12'h001;

  hop_sequencer #(
    .LFSR_BITS    (LFSR_WIDTH)
  ) u_hop (
    .clk          (CORE_CLK),
    .rst          (SYS_RST),
    .enable       (hop_enable),
    .advance      (osc_wrap),
    .hop_vector   (hop_vector),
    .direction_up ()
  );

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      osc_count_reg <= 12'h000;
      period_reg    <= 12'(NOMINAL_CYCLES);
    end else begin
      osc_count_reg <= osc_count_next;
      // a new period every cycle; mid-scale gives the nominal 400 kHz
      if (osc_wrap) begin
        period_reg <= hop_enable ? period_for(hop_vector) : 12'(NOMINAL_CYCLES);
      end
    end
  end

  // channel start pulses: external rising edge or internal wrap
  wire a_start;
  wire ext_half;
  logic [11:0] ext_count_reg;
  logic [11:0] ext_period_reg;
  assign a_start  = (mode_reg == SYNC_EXTERNAL) ? rise : osc_wrap;
  // halfway point of the measured external period places channel b
  assign ext_half = (ext_count_reg == (ext_period_reg >> 1) - 12'h001) &&
                    (ext_period_reg > 12'h001);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ext_count_reg  <= 12'h000;
      ext_period_reg <= 12'h000;
    end else if (rise) begin
      ext_count_reg  <= 12'h000;
      ext_period_reg <= ext_count_reg + 12'h001;
    end else if (ext_count_reg != 12'hFFF) begin
      ext_count_reg  <= ext_count_reg + 12'h001;
    end
  end

  wire b_start;
  assign b_start = (mode_reg == SYNC_EXTERNAL) ? ext_half : half_point;

  // registered outputs
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      HOP_VECTOR                  <= HOP_MID;
      FREQUENCY_HOP_SPREAD_ACTIVE <= 1'b0;
      STEP_DOWN_CHANNEL_A_CLK     <= 1'b0;
      STEP_DOWN_CHANNEL_B_CLK     <= 1'b0;
      EXTERNAL_CLOCK_LOCKED       <= 1'b0;
      LIGHT_LOAD_SAVING_ALLOWED   <= 1'b0;
      PULSE_SKIP_OPERATION_A      <= 1'b0;
      PULSE_SKIP_OPERATION_B      <= 1'b0;
      SINK_ENABLE_A               <= 1'b1;
      SINK_ENABLE_B               <= 1'b1;
    end else begin
      HOP_VECTOR                  <= hop_vector;
      FREQUENCY_HOP_SPREAD_ACTIVE <= hop_enable;
      STEP_DOWN_CHANNEL_A_CLK     <= a_start;
      STEP_DOWN_CHANNEL_B_CLK     <= b_start;
      EXTERNAL_CLOCK_LOCKED       <= (mode_reg == SYNC_EXTERNAL);
      LIGHT_LOAD_SAVING_ALLOWED   <= saving_allowed;
      PULSE_SKIP_OPERATION_A      <= saving_allowed && LIGHT_LOAD_A;
      PULSE_SKIP_OPERATION_B      <= saving_allowed && LIGHT_LOAD_B;
      // pulse-skip is source only; continuous conduction may sink
      SINK_ENABLE_A               <= !(saving_allowed && LIGHT_LOAD_A);
      SINK_ENABLE_B               <= !(saving_allowed && LIGHT_LOAD_B);
    end
  end
endmodule : spread_spectrum_clock_select

/* File: shared/hop_clock_pkg.sv */
package hop_clock_pkg;
  // oscillator cycle period in core clocks at mid-scale (400 kHz nominal at 100 MHz)
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          NOMINAL_PERIOD_NS  = 2500;
  localparam int          NOMINAL_CYCLES     = NOMINAL_PERIOD_NS / CLK_PERIOD_NS;
  // hop spread limit in percent of nominal
  localparam int          SPREAD_PERCENT     = 5;
  localparam int          SPREAD_CYCLES      = (NOMINAL_CYCLES * SPREAD_PERCENT) / 100;
  // hop counter and shift register
  localparam int          HOP_WIDTH          = 4;
  localparam logic [3:0]  HOP_MID            = 4'h8;
  localparam int          LFSR_WIDTH         = 12;
  localparam logic [11:0] LFSR_SEED          = 12'h0001;
  // taps 12,6,4,1 give a maximal-length sequence
  localparam logic [11:0] LFSR_TAPS          = 12'h0829;
  // sync edge detection window and qualification counts
  localparam int          SYNC_WINDOW_NS     = 10000;
  localparam int          SYNC_WINDOW_CYCLES = SYNC_WINDOW_NS / CLK_PERIOD_NS;
  localparam int          SYNC_LOCK_EDGES    = 4;
  localparam int          SYNC_LEVEL_CYCLES  = 4;

  typedef enum logic [1:0] {
    SYNC_LOW,
    SYNC_HIGH,
    SYNC_EXTERNAL
  } sync_mode_type;
endpackage : hop_clock_pkg

/* File: rtl/hop_sequencer.sv */
`timescale 1ns/1ps
module hop_sequencer
  import hop_clock_pkg::*;
#(
  parameter int LFSR_BITS = LFSR_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic             advance,
  output logic [HOP_WIDTH-1:0]  hop_vector,
  output logic                  direction_up
);
  initial begin
    if (LFSR_BITS != 12) $error("hop_sequencer supports a 12-bit shift register only");
  end

  logic [LFSR_BITS-1:0] lfsr_reg;
  logic [LFSR_BITS-1:0] lfsr_next;
  logic [HOP_WIDTH-1:0] count_reg;
  logic [HOP_WIDTH-1:0] count_next;
  wire                  feedback;
  wire                  at_top;
  wire                  at_bottom;

  // galois-free xor of tapped bits; seed nonzero so it never locks up
  assign feedback  = ^(lfsr_reg & LFSR_TAPS);
  assign lfsr_next = advance ? {lfsr_reg[LFSR_BITS-2:0], feedback} : lfsr_reg;
  assign at_top    = (count_reg == 4'hF);
  assign at_bottom = (count_reg == 4'h0);
  // hold at the ends rather than wrap, so the period never jumps full scale
  assign count_next = !enable ? HOP_MID :
                      !advance ? count_reg :
                      (lfsr_reg[LFSR_BITS-1] && !at_top) ? count_reg + 4'h1 :
                      (!lfsr_reg[LFSR_BITS-1] && !at_bottom) ? count_reg - 4'h1 :
                      count_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_reg  <= LFSR_SEED;
      count_reg <= HOP_MID;
    end else begin
      lfsr_reg  <= lfsr_next;
      count_reg <= count_next;
    end
  end

  assign hop_vector   = count_reg;
  assign direction_up = lfsr_reg[LFSR_BITS-1];
endmodule : hop_sequencer

/* File: tb/hop_clock_chk.sv */
`timescale 1ns/1ps
module hop_clock_chk
  import hop_clock_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       SYS_RST,
  input wire logic [3:0] HOP_VECTOR,
  input wire logic       FREQUENCY_HOP_SPREAD_ACTIVE,
  input wire logic       STEP_DOWN_CHANNEL_A_CLK,
  input wire logic       STEP_DOWN_CHANNEL_B_CLK,
  input wire logic       EXTERNAL_CLOCK_LOCKED,
  input wire logic       LIGHT_LOAD_SAVING_ALLOWED,
  input wire logic       PULSE_SKIP_OPERATION_A,
  input wire logic       PULSE_SKIP_OPERATION_B,
  input wire logic       SINK_ENABLE_A,
  input wire logic       SINK_ENABLE_B
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_a_hop;
    STEP_DOWN_CHANNEL_A_CLK && FREQUENCY_HOP_SPREAD_ACTIVE;
  endsequence
  property p_mid;
    !FREQUENCY_HOP_SPREAD_ACTIVE [*2] |-> HOP_VECTOR == HOP_MID;
  endproperty
  a_mid: assert property (p_mid) else $error("hop vector off mid");
  property p_step;
    FREQUENCY_HOP_SPREAD_ACTIVE && $past(FREQUENCY_HOP_SPREAD_ACTIVE)
      |-> 4'(HOP_VECTOR - $past(HOP_VECTOR)) inside {4'h0, 4'h1, 4'hF};
  endproperty
  a_step: assert property (p_step) else $error("hop step too big");
  property p_lock_hop;
    EXTERNAL_CLOCK_LOCKED [*2] |-> !FREQUENCY_HOP_SPREAD_ACTIVE;
  endproperty
  a_lock_hop: assert property (p_lock_hop) else $error("hop while locked");
  property p_lock_save;
    EXTERNAL_CLOCK_LOCKED [*2] |-> !LIGHT_LOAD_SAVING_ALLOWED;
  endproperty
  a_lock_save: assert property (p_lock_save) else $error("saving while locked");
  property p_hop_cont;
    FREQUENCY_HOP_SPREAD_ACTIVE [*3]
      |-> !LIGHT_LOAD_SAVING_ALLOWED && SINK_ENABLE_A && SINK_ENABLE_B;
  endproperty
  a_hop_cont: assert property (p_hop_cont) else $error("hop not continuous");
  property p_pskip;
    !LIGHT_LOAD_SAVING_ALLOWED [*3] |-> !PULSE_SKIP_OPERATION_A && !PULSE_SKIP_OPERATION_B;
  endproperty
  a_pskip: assert property (p_pskip) else $error("pulse skip not allowed");
  property p_sink;
    SINK_ENABLE_A == !PULSE_SKIP_OPERATION_A && SINK_ENABLE_B == !PULSE_SKIP_OPERATION_B;
  endproperty
  a_sink: assert property (p_sink) else $error("sink with pulse skip");
  property p_period;
    s_a_hop |-> ##[238:262] STEP_DOWN_CHANNEL_A_CLK;
  endproperty
  a_period: assert property (p_period) else $error("hop period out of range");
  property p_anti;
    s_a_hop |-> ##[110:140] STEP_DOWN_CHANNEL_B_CLK;
  endproperty
  a_anti: assert property (p_anti) else $error("channel b not antiphase");
endmodule : hop_clock_chk
bind spread_spectrum_clock_select hop_clock_chk chk_u (.CORE_CLK, .SYS_RST, .HOP_VECTOR,
  .FREQUENCY_HOP_SPREAD_ACTIVE, .STEP_DOWN_CHANNEL_A_CLK, .STEP_DOWN_CHANNEL_B_CLK,
  .EXTERNAL_CLOCK_LOCKED, .LIGHT_LOAD_SAVING_ALLOWED, .PULSE_SKIP_OPERATION_A,
  .PULSE_SKIP_OPERATION_B, .SINK_ENABLE_A, .SINK_ENABLE_B);

/* File: tb/sync_source.sv */
`timescale 1ns/1ps
module sync_source (
  // clock and selection: 0 low, 1 high, 2 clock, 3 open
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] half,
  // pin
  output logic            sync_pin
);
  int cnt = 0;
  initial sync_pin = 1'b0;
  always @(posedge clk) begin
    #1;
    cnt = (cnt + 1) % (2 * int'(half));
    case (mode)
      2'd1: sync_pin = 1'b1;
      2'd2: sync_pin = (cnt < int'(half));
      default: sync_pin = 1'b0; // open pin sits at the pulldown level
    endcase
  end
endmodule : sync_source

/* File: tb/test_spread_spectrum_clock_select.sv */
`timescale 1ns/1ps
module test_spread_spectrum_clock_select
  import hop_clock_pkg::*;
;
  logic        core_clk, sys_rst, load_a, load_b, sync_pin;
  logic [1:0]  sync_mode;
  logic [7:0]  sync_half;
  logic [3:0]  hop;
  logic        hop_on, clk_a, clk_b, locked, saving, ps_a, ps_b, snk_a, snk_b;
  logic [31:0] rng = 32'heae3_fad4;
  int          n_errors = 0;
  int          n_compared = 0;
  int          g, k, chg;
  logic [3:0]  last;
  sync_source src_u (.clk(core_clk), .mode(sync_mode), .half(sync_half), .sync_pin(sync_pin));
  spread_spectrum_clock_select #(.WINDOW_CYCLES(50)) dut_u (.CORE_CLK(core_clk),
    .SYS_RST(sys_rst), .SYNC_IN(sync_pin), .LIGHT_LOAD_A(load_a), .LIGHT_LOAD_B(load_b),
    .HOP_VECTOR(hop), .FREQUENCY_HOP_SPREAD_ACTIVE(hop_on), .STEP_DOWN_CHANNEL_A_CLK(clk_a),
    .STEP_DOWN_CHANNEL_B_CLK(clk_b), .EXTERNAL_CLOCK_LOCKED(locked),
    .LIGHT_LOAD_SAVING_ALLOWED(saving), .PULSE_SKIP_OPERATION_A(ps_a),
    .PULSE_SKIP_OPERATION_B(ps_b), .SINK_ENABLE_A(snk_a), .SINK_ENABLE_B(snk_b));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // internal period allowed by the spread limit
  function automatic logic in_spread(input int n);
    return n >= NOMINAL_CYCLES - SPREAD_CYCLES && n <= NOMINAL_CYCLES + SPREAD_CYCLES;
  endfunction : in_spread
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      rng = xs(rng);
      load_a = rng[0];
      load_b = rng[1];
    end
  endtask : cyc
  task automatic loads(input logic a, input logic b, input logic s);
    @(posedge core_clk);
    #1;
    load_a = a;
    load_b = b;
    repeat (3) @(posedge core_clk);
    #1;
    check("pskip_a", ps_a, a & s);
    check("pskip_b", ps_b, b & s);
    check("sink_a", snk_a, !(a & s));
    check("sink_b", snk_b, !(b & s));
  endtask : loads
  // cycles from an a pulse to the following b pulse
  task automatic b_delay(output int n);
    for (k = 0; k < 600 && clk_a !== 1'b1; k++)
      cyc(1);
    for (n = 0; n < 600 && clk_b !== 1'b1; n++)
      cyc(1);
  endtask : b_delay
  task automatic a_gap(output int n);
    for (k = 0; k < 600 && clk_a !== 1'b1; k++)
      cyc(1);
    cyc(1);
    for (n = 1; n < 600 && clk_a !== 1'b1; n++)
      cyc(1);
  endtask : a_gap
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    #300000;
    n_errors++;
    stop_test;
  end
  initial begin
    sys_rst = 1'b1;
    load_a = 1'b0;
    load_b = 1'b0;
    sync_mode = 2'd3;
    sync_half = 8'd30;
    repeat (4) @(posedge core_clk);
    #1;
    check("hop_rst", hop, HOP_MID);
    check("on_rst", hop_on, 1'b0);
    sys_rst = 1'b0;
    cyc(10);
    check("save_open", saving, 1'b1);
    loads(1'b1, 1'b0, 1'b1);
    $display("open pin test done");
    sync_mode = 2'd1;
    cyc(10);
    check("hop_high", hop_on, 1'b1);
    check("save_high", saving, 1'b0);
    loads(1'b1, 1'b1, 1'b0);
    chg = 0;
    last = hop;
    for (int i = 0; i < 12; i++) begin
      a_gap(g);
      check("period", in_spread(g), 1'b1);
      chg += int'(hop !== last);
      last = hop;
    end
    check("hop_moves", chg >= 6, 1'b1);
    $display("high test done");
    sync_mode = 2'd0;
    cyc(10);
    check("hop_low", hop_on, 1'b0);
    check("mid_low", hop, HOP_MID);
    loads(1'b0, 1'b1, 1'b1);
    sync_mode = 2'd2;
    cyc(400);
    check("slow_lock", locked, 1'b0);
    sync_mode = 2'd0;
    cyc(10);
    sync_half = 8'd20;
    sync_mode = 2'd2;
    for (k = 0; k < 400 && locked !== 1'b1; k++)
      cyc(1);
    cyc(3);
    check("lock", locked, 1'b1);
    check("hop_ext", hop_on, 1'b0);
    a_gap(g);
    check("ext_period", g, 16'd40);
    b_delay(g);
    check("ext_anti", g, {8'h00, sync_half});
    loads(1'b1, 1'b1, 1'b0);
    $display("external clock test done");
    sync_mode = 2'd0;
    cyc(120);
    check("unlock", locked, 1'b0);
    check("save_back", saving, 1'b1);
    a_gap(g);
    a_gap(g);
    check("int_period", in_spread(g), 1'b1);
    $display("fallback test done");
    stop_test;
  end
endmodule : test_spread_spectrum_clock_select
